// ===== design/sfid_defs.svh
// sfid_defs.svh: opcodes, swap address, erased and status reset values and timing counts of the id readout
// assumes inclusion by design files only
`ifndef SFID_DEFS_SVH
`define SFID_DEFS_SVH
`define SFID_OP_MAKER_DEV 8'h90
`define SFID_OP_IDENT3 8'h9F
`define SFID_OP_UNIQUE 8'h4B
`define SFID_OP_RELEASE 8'hAB
`define SFID_OP_DPD 8'hB9
`define SFID_ADDR_SWAP 24'h000001
`define SFID_ERASED_BYTE 8'hFF
`define SFID_STATUS_RST 8'h00
`define SFID_CMD_BITS 6'd8
`define SFID_ADDR_END 6'd32
`define SFID_DUMMY_END 6'd40
`define SFID_DIV_HALF 4'd2
`endif

// ===== design/sfid_pkg.sv
// sfid_pkg: types for the host end of the id readout link and its testbench
// assumes sfid_defs.svh for numeric constants
package sfid_pkg;
  typedef enum logic [1:0] {
    SFID_CMD_MAKER_DEV = 2'b00,
    SFID_CMD_IDENT3 = 2'b01,
    SFID_CMD_UNIQUE = 2'b10
  } sfid_cmd_e;
  typedef logic [127:0] sfid_data_t;
endpackage : sfid_pkg

// ===== design/sfid_link_if.sv
// sfid_link_if: serial link between host and device
// assumes the testbench watches the wires only
`timescale 1ns/1ns
interface sfid_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;
  assign miso = miso_oe_n ? 1'b1 : miso_o;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport dev (input sclk, input cs_n, input mosi, output miso_o, output miso_oe_n);
endinterface : sfid_link_if

// ===== design/sfid_device.sv
// sfid_device: flash identification readout, device end
// assumes mode 0 host; link logic runs on the serial clock itself
`timescale 1ns/1ns
`include "sfid_defs.svh"
module sfid_device #(
  parameter logic [7:0] MAKER_ID = 8'h5A,
  parameter logic [7:0] DEV_ID = 8'h13,
  parameter logic [7:0] MEM_TYPE = 8'h64,
  parameter logic [7:0] MEM_CAP = 8'h14,
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  // system
  input wire logic clk_i,
  input wire logic resetn_i,
  // link
  sfid_link_if.dev link,
  // array state
  input wire logic busy_i,
  output logic deep_pd_o,
  output logic [7:0] status_o,
  output logic [7:0] array_byte_o
);
  import sfid_pkg::*;
  // frame phase, decoded from the rising edge count
  typedef enum logic [1:0] {
    SFID_PH_OPCODE = 2'b00,
    SFID_PH_ADDR = 2'b01,
    SFID_PH_DUMMY = 2'b10,
    SFID_PH_DATA = 2'b11
  } sfid_phase_e;
  // ids are arbitrary values, not tied to any maker
  logic [5:0] cnt_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [127:0] sh_q;
  logic out_en_q;
  logic dpd_q;
  logic dpd_req_q;
  logic rel_req_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic dpd_s1_q;
  logic dpd_s2_q;
  logic [7:0] cur_op;
  logic [23:0] cur_addr;
  logic load_now;
  assign cur_op = {op_q[6:0], link.mosi};
  assign cur_addr = {addr_q[22:0], link.mosi};
  assign status_o = `SFID_STATUS_RST;
  assign array_byte_o = `SFID_ERASED_BYTE;
  // an id of all ones could not be told from a released line
  if (MAKER_ID == 8'hFF) begin : g_chk_maker
    $error("maker id must not be all ones");
  end
  if (DEV_ID == 8'hFF) begin : g_chk_dev
    $error("device id must not be all ones");
  end
  if (UNIQUE_ID == '1) begin : g_chk_unique
    $error("unique id must not be all ones");
  end
  // phase of the frame after a given number of rising edges
  function automatic sfid_phase_e phase_of(input logic [5:0] cnt);
    if (cnt < `SFID_CMD_BITS) begin
      return SFID_PH_OPCODE;
    end else if (cnt < `SFID_ADDR_END) begin
      return SFID_PH_ADDR;
    end else if (cnt < `SFID_DUMMY_END) begin
      return SFID_PH_DUMMY;
    end
    return SFID_PH_DATA;
  endfunction : phase_of
  // rising edge count after which an opcode starts output, zero for none
  function automatic logic [5:0] out_start(input logic [7:0] op);
    logic [5:0] n;
    case (op)
      `SFID_OP_IDENT3: n = `SFID_CMD_BITS;
      `SFID_OP_MAKER_DEV: n = `SFID_ADDR_END;
      `SFID_OP_UNIQUE: n = `SFID_DUMMY_END;
      default: n = 6'd0;
    endcase
    return n;
  endfunction : out_start
  // identity word loaded into the shifter, msb first
  function automatic logic [127:0] id_word(input logic [7:0] op, input logic [23:0] addr);
    logic [127:0] w;
    w = UNIQUE_ID;
    if (op == `SFID_OP_IDENT3) begin
      w = {MAKER_ID, MEM_TYPE, MEM_CAP, 104'h0};
    end else if (op == `SFID_OP_MAKER_DEV && addr == `SFID_ADDR_SWAP) begin
      w = {DEV_ID, MAKER_ID, 112'h0};
    end else if (op == `SFID_OP_MAKER_DEV) begin
      w = {MAKER_ID, DEV_ID, 112'h0};
    end
    return w;
  endfunction : id_word
  // link domain busy level
  always_ff @(posedge link.sclk or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= busy_i;
      busy_s2_q <= busy_s1_q;
    end
  end
  // rising edge count; cs_n high acts as async reset of the frame
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_q <= 6'd0;
    end else if (cnt_q != `SFID_DUMMY_END + 6'd1) begin
      cnt_q <= cnt_q + 6'd1;
    end
  end
  // opcode capture
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      op_q <= 8'h00;
    end else if (phase_of(cnt_q) == SFID_PH_OPCODE) begin
      op_q <= cur_op;
    end
  end
  // address capture
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      addr_q <= 24'h000000;
    end else if (phase_of(cnt_q) == SFID_PH_ADDR) begin
      addr_q <= cur_addr;
    end
  end
  // power mode requests, decided on the last opcode bit
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      dpd_req_q <= 1'b0;
      rel_req_q <= 1'b0;
    end else if (cnt_q == `SFID_CMD_BITS - 6'd1) begin
      dpd_req_q <= (cur_op == `SFID_OP_DPD) && !busy_s2_q;
      rel_req_q <= (cur_op == `SFID_OP_RELEASE);
    end
  end
  // deep power-down mode, applied at deselection
  always_ff @(posedge link.cs_n or negedge resetn_i) begin
    if (!resetn_i) begin
      dpd_q <= 1'b0;
    end else if (rel_req_q) begin
      dpd_q <= 1'b0;
    end else if (dpd_req_q) begin
      dpd_q <= 1'b1;
    end
  end
  // output starts once the header of a known opcode is in, except for ident3 while busy
  assign load_now = (out_start(op_q) != 6'd0) && (cnt_q == out_start(op_q))
    && !(op_q == `SFID_OP_IDENT3 && busy_s2_q);
  // falling edge output shifter
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      sh_q <= 128'h0;
      out_en_q <= 1'b0;
    end else if (!dpd_q) begin
      if (load_now) begin
        sh_q <= id_word(op_q, addr_q);
        out_en_q <= 1'b1;
      end else if (out_en_q) begin
        sh_q <= {sh_q[126:0], 1'b0};
      end
    end
  end
  assign link.miso_o = sh_q[127];
  assign link.miso_oe_n = !out_en_q;
  // system domain view of power-down
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dpd_s1_q <= 1'b0;
      dpd_s2_q <= 1'b0;
    end else begin
      dpd_s1_q <= dpd_q;
      dpd_s2_q <= dpd_s1_q;
    end
  end
  assign deep_pd_o = dpd_s2_q;
endmodule : sfid_device

// ===== design/sfid_host.sv
// sfid_host: host end issuing id read commands
// assumes link sclk derived from clk_i by a divider
`timescale 1ns/1ns
`include "sfid_defs.svh"
module sfid_host (
  // system
  input wire logic clk_i,
  input wire logic resetn_i,
  // request
  input wire logic start_i,
  input wire sfid_pkg::sfid_cmd_e cmd_i,
  input wire logic swap_i,
  input wire logic [7:0] nbits_i,
  output logic busy_o,
  output logic done_o,
  output logic [127:0] data_o,
  // link
  sfid_link_if.host link
);
  import sfid_pkg::*;
  logic [1:0] div_q;
  logic sclk_q;
  logic cs_n_q;
  logic [39:0] tx_q;
  logic [7:0] hdr_q;
  logic [7:0] rx_cnt_q;
  logic [7:0] nb_q;
  logic [7:0] hbits_q;
  logic [127:0] rx_q;
  logic done_q;
  logic miso_s1_q;
  logic miso_s2_q;
  logic tick;
  assign tick = (div_q == 2'd1);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      miso_s1_q <= 1'b1;
      miso_s2_q <= 1'b1;
    end else begin
      miso_s1_q <= link.miso;
      miso_s2_q <= miso_s1_q;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 2'd0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      tx_q <= 40'h0;
      hdr_q <= 8'd0;
      rx_cnt_q <= 8'd0;
      nb_q <= 8'd0;
      hbits_q <= 8'd0;
      rx_q <= 128'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      div_q <= cs_n_q ? 2'd0 : div_q + 2'd1;
      if (cs_n_q) begin
        if (start_i) begin
          cs_n_q <= 1'b0;
          rx_cnt_q <= 8'd0;
          nb_q <= nbits_i;
          unique case (cmd_i)
            SFID_CMD_MAKER_DEV: begin
              tx_q <= {`SFID_OP_MAKER_DEV, 23'h0, swap_i, 8'h00};
              hbits_q <= 8'd32;
            end
            SFID_CMD_IDENT3: begin
              tx_q <= {`SFID_OP_IDENT3, 32'h0};
              hbits_q <= 8'd8;
            end
            default: begin
              tx_q <= {`SFID_OP_UNIQUE, 32'h0};
              hbits_q <= 8'd40;
            end
          endcase
          hdr_q <= 8'd0;
        end
      end else if (tick) begin
        sclk_q <= !sclk_q;
        if (!sclk_q) begin
          if (hdr_q >= hbits_q) begin
            rx_q <= {rx_q[126:0], miso_s2_q};
            rx_cnt_q <= rx_cnt_q + 8'd1;
          end
          hdr_q <= (hdr_q == 8'hFF) ? hdr_q : hdr_q + 8'd1;
        end else begin
          tx_q <= {tx_q[38:0], 1'b0};
          if (hdr_q >= hbits_q && rx_cnt_q >= nb_q) begin
            cs_n_q <= 1'b1;
            done_q <= 1'b1;
          end
        end
      end
    end
  end
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = tx_q[39];
  assign busy_o = !cs_n_q;
  assign done_o = done_q;
  assign data_o = rx_q;
endmodule : sfid_host

// ===== verif/sfid_link_props.sv
// sfid_link_props: wire checks on the id readout link
// assumes host clock and reset sample all link signals
`timescale 1ns/1ns
module sfid_link_props (
  // system
  input wire logic clk_i,
  input wire logic resetn_i,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  logic sclk_q;
  logic [7:0] rise_q;
  // sclk rising edges seen in this frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_q <= 1'b0;
      rise_q <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rise_q <= 8'h00;
      end else if (sclk && !sclk_q && rise_q != 8'hFF) begin
        rise_q <= rise_q + 8'h01;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_sel;
    $fell(cs_n);
  endsequence
  sequence s_first_clk;
    ##[1:8] $rose(sclk);
  endsequence
  a_first_clock: assert property (s_sel |-> s_first_clk)
    else $error("no sclk after select");
  a_idle_clk_low: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("sclk moves while deselected");
  a_hiz_deselect: assert property (cs_n && $past(cs_n) |-> miso_oe_n)
    else $error("miso driven while deselected");
  a_stop_on_cs: assert property ($rose(cs_n) |=> miso_oe_n)
    else $error("miso still driven after deselect");
  a_no_hdr_drive: assert property (!miso_oe_n |-> rise_q >= 8'h08)
    else $error("miso driven during opcode");
  a_out_on_fall: assert property (!miso_oe_n && $past(!miso_oe_n) && $changed(miso_o)
    |-> $fell(sclk))
    else $error("miso changed off falling sclk");
  a_mosi_low_clk: assert property (!cs_n && $changed(mosi) |-> !sclk)
    else $error("mosi changed while sclk high");
  a_sclk_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase not four cycles");
endmodule : sfid_link_props

// ===== verif/testbench.sv
// testbench: host and device joined by the link, id reads checked at the host
// assumes device id parameters left at their defaults
`timescale 1ns/1ns
module testbench;
  import sfid_pkg::*;
  typedef struct {sfid_cmd_e c; logic s; logic [7:0] n; logic b; logic [127:0] e;} sfid_row_s;
  logic clk_i = 1'b0;
  logic lclk = 1'b0;
  logic resetn_i = 1'b0;
  logic start_i = 1'b0;
  sfid_cmd_e cmd_i = SFID_CMD_MAKER_DEV;
  logic swap_i = 1'b0;
  logic [7:0] nbits_i = 8'h00;
  logic busy_i = 1'b0;
  logic busy_o, done_o, deep_pd_o;
  logic [127:0] data_o;
  logic [7:0] status_o, array_byte_o;
  int fail_count = 0;
  int total_checks = 0;
  sfid_row_s rows [7] = '{
    '{SFID_CMD_MAKER_DEV, 1'b0, 8'h10, 1'b0, 128'h5A13},
    '{SFID_CMD_MAKER_DEV, 1'b1, 8'h10, 1'b0, 128'h135A},
    '{SFID_CMD_IDENT3, 1'b0, 8'h18, 1'b0, 128'h5A6414},
    '{SFID_CMD_UNIQUE, 1'b0, 8'h80, 1'b0, 128'h0123456789ABCDEF0F1E2D3C4B5A6978},
    '{SFID_CMD_IDENT3, 1'b0, 8'h18, 1'b1, 128'hFFFFFF},
    '{SFID_CMD_IDENT3, 1'b0, 8'h05, 1'b0, 128'h0B},
    '{SFID_CMD_UNIQUE, 1'b0, 8'h80, 1'b0, 128'h0123456789ABCDEF0F1E2D3C4B5A6978}};
  always #4 clk_i = ~clk_i;
  initial begin
    #3;
    forever #16 lclk = ~lclk;
  end
  sfid_link_if sfid_link_if_inst ();
  sfid_host sfid_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i),
    .cmd_i(cmd_i), .swap_i(swap_i), .nbits_i(nbits_i), .busy_o(busy_o), .done_o(done_o),
    .data_o(data_o), .link(sfid_link_if_inst.host));
  sfid_device sfid_device_inst (.clk_i(lclk), .resetn_i(resetn_i),
    .link(sfid_link_if_inst.dev), .busy_i(busy_i), .deep_pd_o(deep_pd_o),
    .status_o(status_o), .array_byte_o(array_byte_o));
  sfid_link_props sfid_link_props_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .sclk(sfid_link_if_inst.sclk), .cs_n(sfid_link_if_inst.cs_n),
    .mosi(sfid_link_if_inst.mosi), .miso_o(sfid_link_if_inst.miso_o),
    .miso_oe_n(sfid_link_if_inst.miso_oe_n));
  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic run(input sfid_row_s r);
    int k;
    logic [127:0] m;
    m = (r.n == 8'h80) ? '1 : ((128'h1 << r.n) - 128'h1);
    @(posedge clk_i);
    busy_i <= r.b;
    cmd_i <= r.c;
    swap_i <= r.s;
    nbits_i <= r.n;
    repeat (4) @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (k = 0; k < 3000 && done_o !== 1'b1; k++) @(negedge clk_i);
    check("done", done_o, 1'b1);
    check("data", data_o & m, r.e);
    @(posedge clk_i);
    busy_i <= 1'b0;
  endtask : run
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check("busy", busy_o, 1'b0);
    check("status", status_o, 8'h00);
    check("array", array_byte_o, 8'hFF);
    check("pdown", deep_pd_o, 1'b0);
    foreach (rows[i]) run(rows[i]);
    repeat (20) @(negedge clk_i);
    check("busy_end", busy_o, 1'b0);
    check("pdown_end", deep_pd_o, 1'b0);
    check("status_end", status_o, 8'h00);
    summarize();
  end
endmodule : testbench
